// ---- rtl/di_sync_if.sv ----
`timescale 1ns/100ps
interface di_sync_if;
  logic [seg_sel_pkg::DI_NUM-1:0] raw;
  logic [seg_sel_pkg::DI_NUM-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface : di_sync_if

// ---- rtl/di_synchronizer.sv ----
`timescale 1ns/100ps
module di_synchronizer
  import seg_sel_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // terminal levels
  di_sync_if.sync dio
);

  logic [DI_NUM-1:0] meta_q;
  logic [DI_NUM-1:0] meta_d;
  logic [DI_NUM-1:0] stab_q;
  logic [DI_NUM-1:0] stab_d;

  // the first stage feeds only the second
  always_comb
  begin
    meta_d = dio.raw;
    stab_d = meta_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      stab_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign dio.synced = stab_q;

endmodule : di_synchronizer

// ---- rtl/position_segment_selector.sv ----
// How it works
// - Control mode 0 means position control, 16 means fieldbus, anything else another mode.
// - Command source 0 takes the external pulse input, 1 takes the internal segment table.
// - Gear numerator and denominator each accept only values from 1 to 1073741824.
// - The segment number is the plain binary value of select bits four down to zero.
// - A rising trigger edge starts the segment the select bits currently choose.
// - Segment zero runs an origin return; every other segment is an ordinary move.
// - A rising halt edge stops the running segment at once.
// - Terminals take roles by code: trigger 0x16, select bits 0x17 to 0x1b, halt 0x20.
// - Writing 0 to 31 to the segment command register selects and triggers that segment.
// - Writing 1000 there halts the segment; only the low 16 bits are decoded, and other values there outside 0 to 31 are ignored.
// - While a segment runs the command register reads 10000 plus its number.
// - When a segment ends the command register reads 20000 plus its number.
// - With the servo disabled the register reads 20000 and writes start nothing.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
module position_segment_selector
  import seg_sel_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [seg_sel_pkg::ADDR_W-1:0] addr,
  input wire logic [seg_sel_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [seg_sel_pkg::DATA_W-1:0] rdata,
  // digital input terminals, asynchronous
  input wire logic [seg_sel_pkg::DI_NUM-1:0] digital_input_terminal,
  // drive state and planner handshake
  input wire logic servo_enabled,
  input wire logic segment_done,
  // segment command to the planner
  output logic segment_start,
  output logic segment_halt,
  output logic segment_running,
  output logic origin_return,
  output logic [seg_sel_pkg::SEL_W-1:0] segment_number,
  // mode decode
  output logic position_mode,
  output logic fieldbus_mode,
  output logic other_mode,
  output logic internal_profile,
  // electronic gear
  output logic [seg_sel_pkg::DATA_W-1:0] gear_numerator,
  output logic [seg_sel_pkg::DATA_W-1:0] gear_denominator
);

  import seg_sel_pkg::*;

  // terminal synchroniser

  di_sync_if dio ();

  assign dio.raw = digital_input_terminal;

  di_synchronizer u_sync (
    .clk (clk),
    .rst (rst),
    .dio (dio.sync)
  );

  // configuration registers

  logic [15:0] ctrl_mode_q;
  logic [15:0] ctrl_mode_d;
  logic [31:0] gear_num_q;
  logic [31:0] gear_num_d;
  logic [31:0] gear_den_q;
  logic [31:0] gear_den_d;
  logic [15:0] cmd_src_q;
  logic [15:0] cmd_src_d;
  logic [FUNC_W-1:0] di_func_q [DI_NUM];
  logic [FUNC_W-1:0] di_func_d [DI_NUM];

  logic wr_ctrl;
  logic wr_num;
  logic wr_den;
  logic wr_src;
  logic wr_seg;
  logic gear_ok;

  assign wr_ctrl = wr && (addr == OFF_CTRL_MODE);
  assign wr_num = wr && (addr == OFF_GEAR_NUM);
  assign wr_den = wr && (addr == OFF_GEAR_DEN);
  assign wr_src = wr && (addr == OFF_CMD_SRC);
  assign wr_seg = wr && (addr == OFF_SEG_CMD);
  // out-of-range gear writes are dropped; reset loads zero into both gear registers
  assign gear_ok = (wdata >= GEAR_MIN) && (wdata <= GEAR_MAX);

  always_comb
  begin
    ctrl_mode_d = ctrl_mode_q;
    gear_num_d = gear_num_q;
    gear_den_d = gear_den_q;
    cmd_src_d = cmd_src_q;
    if (wr_ctrl)
    begin
      ctrl_mode_d = wdata[15:0];
    end
    if (wr_num && gear_ok)
    begin
      gear_num_d = wdata;
    end
    if (wr_den && gear_ok)
    begin
      gear_den_d = wdata;
    end
    // only the two defined source codes are taken
    if (wr_src && (wdata[15:0] <= SRC_INTERNAL))
    begin
      cmd_src_d = wdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_mode_q <= RST_CTRL_MODE;
      gear_num_q <= RST_GEAR;
      gear_den_q <= RST_GEAR;
      cmd_src_q <= RST_CMD_SRC;
    end
    else
    begin
      ctrl_mode_q <= ctrl_mode_d;
      gear_num_q <= gear_num_d;
      gear_den_q <= gear_den_d;
      cmd_src_q <= cmd_src_d;
    end
  end

  // terminal roles

  logic [DI_NUM-1:0] is_trig;
  logic [DI_NUM-1:0] is_halt;
  logic [DI_NUM-1:0] is_sel [SEL_W];

  genvar gi;
  genvar gb;
  generate
    for (gi = 0; gi < DI_NUM; gi++)
    begin : g_term
      always_comb
      begin
        di_func_d[gi] = di_func_q[gi];
        if (wr && (addr == OFF_DI_FUNC_BASE + 12'(gi)))
        begin
          di_func_d[gi] = wdata[FUNC_W-1:0];
        end
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          di_func_q[gi] <= RST_DI_FUNC;
        end
        else
        begin
          di_func_q[gi] <= di_func_d[gi];
        end
      end

      assign is_trig[gi] = dio.synced[gi] && (di_func_q[gi] == FUNC_TRIG);
      assign is_halt[gi] = dio.synced[gi] && (di_func_q[gi] == FUNC_HALT);
      for (gb = 0; gb < SEL_W; gb++)
      begin : g_bit
        // bits 0..3 use consecutive codes, bit 4 its own code
        localparam logic [7:0] CODE = (gb == SEL_W - 1) ? FUNC_SEL4 : FUNC_SEL0 + 8'(gb);
        assign is_sel[gb][gi] = dio.synced[gi] && (di_func_q[gi] == CODE);
      end
    end
  endgenerate

  logic trig_lvl;
  logic halt_lvl;
  logic [SEL_W-1:0] sel_now;

  assign trig_lvl = |is_trig;
  assign halt_lvl = |is_halt;

  generate
    for (gb = 0; gb < SEL_W; gb++)
    begin : g_sel
      assign sel_now[gb] = |is_sel[gb];
    end
  endgenerate

  // edge detection

  logic trig_prev_q;
  logic trig_prev_d;
  logic halt_prev_q;
  logic halt_prev_d;
  logic trig_edge;
  logic halt_edge;

  always_comb
  begin
    trig_prev_d = trig_lvl;
    halt_prev_d = halt_lvl;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trig_prev_q <= 1'b0;
      halt_prev_q <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trig_prev_d;
      halt_prev_q <= halt_prev_d;
    end
  end

  assign trig_edge = trig_lvl && !trig_prev_q;
  assign halt_edge = halt_lvl && !halt_prev_q;

  // mode decode

  ctrl_class_t ctrl_class;
  logic internal_src;
  logic seg_ready;

  always_comb
  begin
    if (ctrl_mode_q == MODE_POSITION)
    begin
      ctrl_class = CLASS_POSITION;
    end
    else if (ctrl_mode_q == MODE_FIELDBUS)
    begin
      ctrl_class = CLASS_FIELDBUS;
    end
    else
    begin
      ctrl_class = CLASS_OTHER;
    end
  end

  assign internal_src = (cmd_src_q == SRC_INTERNAL);
  // segments only start in position mode from the internal table with the servo on
  assign seg_ready = servo_enabled && (ctrl_class == CLASS_POSITION) && internal_src;

  // segment sequencer

  seg_state_t state_q;
  seg_state_t state_d;
  logic [SEL_W-1:0] seg_num_q;
  logic [SEL_W-1:0] seg_num_d;
  logic [15:0] seg_status_q;
  logic [15:0] seg_status_d;
  logic start_q;
  logic start_d;
  logic halt_q;
  logic halt_d;
  logic origin_q;
  logic origin_d;
  logic run_q;
  logic run_d;

  logic cmd_start;
  logic cmd_stop;
  logic start_req;
  logic halt_req;
  logic [SEL_W-1:0] start_num;

  assign cmd_start = wr_seg && (wdata[15:0] <= SEG_MAX) && seg_ready;
  assign cmd_stop = wr_seg && (wdata[15:0] == CMD_STOP);
  assign start_req = cmd_start || (trig_edge && seg_ready);
  assign halt_req = cmd_stop || halt_edge;
  // a register write wins over a simultaneous terminal edge
  assign start_num = cmd_start ? wdata[SEL_W-1:0] : sel_now;

  always_comb
  begin
    state_d = state_q;
    seg_num_d = seg_num_q;
    seg_status_d = seg_status_q;
    start_d = 1'b0;
    halt_d = 1'b0;
    origin_d = origin_q;
    unique case (state_q)
      SEG_IDLE:
      begin
        if (start_req && !halt_req)
        begin
          state_d = SEG_RUN;
          seg_num_d = start_num;
          start_d = 1'b1;
          origin_d = (start_num == '0);
          seg_status_d = STAT_BUSY + {11'h000, start_num};
        end
      end
      SEG_RUN:
      begin
        if (halt_req || !servo_enabled)
        begin
          // halt beats everything so a stop is never swallowed
          state_d = SEG_IDLE;
          halt_d = 1'b1;
          seg_status_d = STAT_DONE + {11'h000, seg_num_q};
        end
        else if (start_req)
        begin
          seg_num_d = start_num;
          start_d = 1'b1;
          origin_d = (start_num == '0);
          seg_status_d = STAT_BUSY + {11'h000, start_num};
        end
        else if (segment_done)
        begin
          state_d = SEG_IDLE;
          seg_status_d = STAT_DONE + {11'h000, seg_num_q};
        end
      end
    endcase
    run_d = (state_d == SEG_RUN);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= SEG_IDLE;
      seg_num_q <= '0;
      seg_status_q <= RST_SEG_STATUS;
      start_q <= 1'b0;
      halt_q <= 1'b0;
      origin_q <= 1'b0;
      run_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      seg_num_q <= seg_num_d;
      seg_status_q <= seg_status_d;
      start_q <= start_d;
      halt_q <= halt_d;
      origin_q <= origin_d;
      run_q <= run_d;
    end
  end

  // output flops

  logic [2:0] mode_q;
  logic [2:0] mode_d;
  logic src_q;
  logic src_d;

  always_comb
  begin
    mode_d = {ctrl_class == CLASS_OTHER, ctrl_class == CLASS_FIELDBUS,
              ctrl_class == CLASS_POSITION};
    src_d = internal_src;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= 3'h1;
      src_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      src_q <= src_d;
    end
  end

  // read path

  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [15:0] seg_read;

  // a disabled drive always reports ready with no segment
  assign seg_read = servo_enabled ? seg_status_q : STAT_DONE;

  always_comb
  begin
    rdata_d = '0;
    if (rd)
    begin
      unique case (addr)
        OFF_CTRL_MODE: rdata_d = {16'h0000, ctrl_mode_q};
        OFF_GEAR_NUM: rdata_d = gear_num_q;
        OFF_GEAR_DEN: rdata_d = gear_den_q;
        OFF_CMD_SRC: rdata_d = {16'h0000, cmd_src_q};
        OFF_SEG_CMD: rdata_d = {16'h0000, seg_read};
        OFF_DI_LEVEL: rdata_d = {24'h000000, dio.synced};
        default:
        begin
          for (int i = 0; i < DI_NUM; i++)
          begin
            if (addr == OFF_DI_FUNC_BASE + 12'(i))
            begin
              rdata_d = {24'h000000, di_func_q[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign segment_start = start_q;
  assign segment_halt = halt_q;
  assign segment_running = run_q;
  assign origin_return = origin_q;
  assign segment_number = seg_num_q;
  assign position_mode = mode_q[0];
  assign fieldbus_mode = mode_q[1];
  assign other_mode = mode_q[2];
  assign internal_profile = src_q;
  assign gear_numerator = gear_num_q;
  assign gear_denominator = gear_den_q;

endmodule : position_segment_selector

// ---- rtl/seg_sel_pkg.sv ----
package seg_sel_pkg;

  // bus and terminal geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int DI_NUM = 8;
  localparam int FUNC_W = 8;
  localparam int SEL_W = 5;

  // register offsets
  localparam logic [11:0] OFF_CTRL_MODE = 12'h000;
  localparam logic [11:0] OFF_GEAR_NUM = 12'h204;
  localparam logic [11:0] OFF_GEAR_DEN = 12'h206;
  localparam logic [11:0] OFF_CMD_SRC = 12'h208;
  localparam logic [11:0] OFF_SEG_CMD = 12'h898;
  localparam logic [11:0] OFF_DI_FUNC_BASE = 12'h300;
  localparam logic [11:0] OFF_DI_LEVEL = 12'h310;

  // values after reset
  localparam logic [15:0] RST_CTRL_MODE = 16'h0000;
  localparam logic [31:0] RST_GEAR = 32'h0000_0000;
  localparam logic [15:0] RST_CMD_SRC = 16'h0000;
  localparam logic [15:0] RST_SEG_STATUS = 16'h2710;
  localparam logic [7:0] RST_DI_FUNC = 8'h00;

  // control mode and command source codes
  localparam logic [15:0] MODE_POSITION = 16'h0000;
  localparam logic [15:0] MODE_FIELDBUS = 16'h0010;
  localparam logic [15:0] SRC_EXTERNAL = 16'h0000;
  localparam logic [15:0] SRC_INTERNAL = 16'h0001;

  // gear ratio limits
  localparam logic [31:0] GEAR_MIN = 32'h0000_0001;
  localparam logic [31:0] GEAR_MAX = 32'h4000_0000;

  // terminal function codes
  localparam logic [7:0] FUNC_TRIG = 8'h16;
  localparam logic [7:0] FUNC_SEL0 = 8'h17;
  localparam logic [7:0] FUNC_SEL4 = 8'h1b;
  localparam logic [7:0] FUNC_HALT = 8'h20;

  // segment command register values
  localparam logic [15:0] SEG_MAX = 16'h001f;
  localparam logic [15:0] CMD_STOP = 16'h03e8;
  localparam logic [15:0] STAT_BUSY = 16'h2710;
  localparam logic [15:0] STAT_DONE = 16'h4e20;

  typedef enum logic [0:0] {SEG_IDLE, SEG_RUN} seg_state_t;
  typedef enum logic [1:0] {CLASS_POSITION, CLASS_FIELDBUS, CLASS_OTHER} ctrl_class_t;

endpackage : seg_sel_pkg

// ---- tb/plc_planner_model.sv ----
`timescale 1ns/100ps
module plc_planner_model
  import seg_sel_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // planner handshake
  input wire logic segment_start,
  input wire logic segment_halt,
  output logic segment_done,
  // terminal levels
  output logic [seg_sel_pkg::DI_NUM-1:0] pins
);
  int dly = 4;
  int cnt_q;
  initial pins = '0;
  // a restart reloads the count; a halt drops it, so a done follows a stop only when the halt lands on a count of 1
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 0;
      segment_done <= 1'b0;
    end
    else
    begin
      segment_done <= cnt_q == 1;
      if (segment_start)
        cnt_q <= dly;
      else if (segment_halt)
        cnt_q <= 0;
      else if (cnt_q > 0)
        cnt_q <= cnt_q - 1;
    end
  end
  task drive(input logic [7:0] v);
    @(posedge clk);
    pins <= v;
  endtask : drive
endmodule : plc_planner_model

// ---- tb/position_segment_selector_chk.sv ----
`timescale 1ns/100ps
module position_segment_selector_chk
  import seg_sel_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [seg_sel_pkg::ADDR_W-1:0] addr,
  input wire logic [seg_sel_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [seg_sel_pkg::DATA_W-1:0] rdata,
  // drive state and planner
  input wire logic servo_enabled,
  input wire logic segment_done,
  input wire logic segment_start,
  input wire logic segment_halt,
  input wire logic segment_running,
  input wire logic origin_return,
  input wire logic [seg_sel_pkg::SEL_W-1:0] segment_number,
  // mode decode
  input wire logic position_mode,
  input wire logic fieldbus_mode,
  input wire logic internal_profile
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic ran_q;
  logic hit;
  assign hit = addr == OFF_SEG_CMD;
  // idle status after a re-enable is left open, so only judge it once a segment ran
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ran_q <= 1'b0;
    else if (!servo_enabled)
      ran_q <= 1'b0;
    else if (segment_start)
      ran_q <= 1'b1;
  end
  property p_mode;
    wr && addr == OFF_CTRL_MODE && wdata[15:0] == MODE_FIELDBUS |-> ##[1:2] fieldbus_mode;
  endproperty
  a_mode: assert property (p_mode) else $error("fieldbus mode missing");
  property p_origin;
    segment_start |-> origin_return == (segment_number == 5'h00);
  endproperty
  a_origin: assert property (p_origin) else $error("origin flag wrong");
  property p_go;
    wr && hit && wdata < 32'h20 && servo_enabled && position_mode && internal_profile
      |=> segment_start && segment_number == $past(wdata[4:0]);
  endproperty
  a_go: assert property (p_go) else $error("command write did not start");
  property p_stop;
    wr && hit && wdata == {16'h0, CMD_STOP} && segment_running && !segment_done
      |=> segment_halt && !segment_running;
  endproperty
  a_stop: assert property (p_stop) else $error("stop write did not halt");
  property p_busy;
    rd && hit && servo_enabled && segment_running && !segment_done
      |=> rdata == {16'h0, STAT_BUSY + {11'h0, $past(segment_number)}};
  endproperty
  a_busy: assert property (p_busy) else $error("busy status wrong");
  property p_done;
    rd && hit && servo_enabled && $past(servo_enabled) && ran_q && !segment_running
      |=> rdata == {16'h0, STAT_DONE + {11'h0, $past(segment_number)}};
  endproperty
  a_done: assert property (p_done) else $error("done status wrong");
  property p_off;
    rd && hit && !servo_enabled && !$past(servo_enabled) |=> rdata == {16'h0, STAT_DONE};
  endproperty
  a_off: assert property (p_off) else $error("disabled status wrong");
  property p_gate;
    segment_start |-> $past(servo_enabled);
  endproperty
  a_gate: assert property (p_gate) else $error("start while disabled");
endmodule : position_segment_selector_chk

bind position_segment_selector position_segment_selector_chk u_chk (.clk, .rst, .addr, .wdata,
  .wr, .rd, .rdata, .servo_enabled, .segment_done, .segment_start, .segment_halt,
  .segment_running, .origin_return, .segment_number, .position_mode, .fieldbus_mode,
  .internal_profile);

// ---- tb/position_segment_selector_tb_top.sv ----
`timescale 1ns/100ps
module position_segment_selector_tb_top;
  import seg_sel_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic servo_enabled = 1'b1;
  logic [DATA_W-1:0] rdata, gear_numerator, gear_denominator;
  logic [DI_NUM-1:0] pins;
  logic segment_done, segment_start, segment_halt, segment_running, origin_return;
  logic [SEL_W-1:0] segment_number;
  logic position_mode, fieldbus_mode, other_mode, internal_profile;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [11:0] ga;
  logic [4:0] n;
  logic [15:0] mv[4] = '{16'h0000, 16'h0010, 16'h0005, 16'h000b};
  logic [4:0] sv[2] = '{5'h16, 5'h09};
  always #50 clk = ~clk;
  position_segment_selector u_dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .digital_input_terminal(pins), .servo_enabled, .segment_done, .segment_start,
    .segment_halt, .segment_running, .origin_return, .segment_number, .position_mode,
    .fieldbus_mode, .other_mode, .internal_profile, .gear_numerator, .gear_denominator);
  plc_planner_model u_plc (.clk, .rst, .segment_start, .segment_halt, .segment_done, .pins);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk
  // terminal path latency depends on the synchroniser, so poll with a bound
  task wait_ev(input logic halt);
    repeat (12)
    begin
      @(posedge clk);
      #1;
      if ((halt ? segment_halt : segment_start) === 1'b1) break;
    end
  endtask : wait_ev
  task results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      results;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFF_CTRL_MODE, 32'h0);
    rd_chk(OFF_GEAR_NUM, 32'h0);
    rd_chk(OFF_GEAR_DEN, 32'h0);
    rd_chk(OFF_CMD_SRC, 32'h0);
    rd_chk(OFF_SEG_CMD, {16'h0, RST_SEG_STATUS});
    rd_chk(12'h7fc, 32'h0);
    $display("test reset done");
    foreach (mv[i])
    begin
      wr_reg(OFF_CTRL_MODE, {16'h0, mv[i]});
      repeat (2) @(posedge clk);
      #1;
      chk({position_mode, fieldbus_mode, other_mode},
        {mv[i] == 0, mv[i] == 16'h10, mv[i] != 0 && mv[i] != 16'h10});
    end
    wr_reg(OFF_CTRL_MODE, 32'h0);
    $display("test modes done");
    wr_reg(OFF_SEG_CMD, 32'h3);
    chk(segment_start, 1'b0);
    chk(internal_profile, 1'b0);
    wr_reg(OFF_CMD_SRC, 32'h1);
    wr_reg(OFF_CMD_SRC, 32'h2);
    rd_chk(OFF_CMD_SRC, 32'h1);
    chk(internal_profile, 1'b1);
    $display("test source done");
    for (int g = 0; g < 2; g++)
    begin
      ga = g ? OFF_GEAR_DEN : OFF_GEAR_NUM;
      wr_reg(ga, GEAR_MAX);
      wr_reg(ga, 32'h0);
      wr_reg(ga, GEAR_MAX + 32'h1);
      rd_chk(ga, GEAR_MAX);
      wr_reg(ga, GEAR_MIN);
      rd_chk(ga, GEAR_MIN);
    end
    chk(gear_numerator, GEAR_MIN);
    chk(gear_denominator, GEAR_MIN);
    $display("test gear done");
    for (int k = 0; k < 2; k++)
    begin
      n = k ? 5'h1f : 5'h00;
      u_plc.dly = k ? 2 : 20;
      wr_reg(OFF_SEG_CMD, {27'h0, n});
      chk(segment_start, 1'b1);
      chk(segment_number, n);
      chk(segment_running, 1'b1);
      chk(origin_return, n == 0);
      if (k == 0) rd_chk(OFF_SEG_CMD, {16'h0, STAT_BUSY + n});
      repeat (25) @(posedge clk);
      rd_chk(OFF_SEG_CMD, {16'h0, STAT_DONE + n});
    end
    $display("test segments done");
    wr_reg(OFF_SEG_CMD, 32'h20);
    chk(segment_start, 1'b0);
    wr_reg(OFF_SEG_CMD, 32'h3e7);
    chk(segment_start, 1'b0);
    u_plc.dly = 60;
    wr_reg(OFF_SEG_CMD, 32'h7);
    // a second number while running restarts with it
    wr_reg(OFF_SEG_CMD, 32'h9);
    chk(segment_start, 1'b1);
    chk(segment_number, 5'h09);
    rd_chk(OFF_SEG_CMD, {16'h0, STAT_BUSY + 16'h9});
    wr_reg(OFF_SEG_CMD, {16'h0, CMD_STOP});
    chk(segment_halt, 1'b1);
    chk(segment_running, 1'b0);
    rd_chk(OFF_SEG_CMD, {16'h0, STAT_DONE + 16'h9});
    $display("test stop done");
    for (int i = 0; i < 7; i++)
      wr_reg(OFF_DI_FUNC_BASE + 12'(i),
        {24'h0, i < 5 ? FUNC_SEL0 + 8'(i) : (i == 5 ? FUNC_TRIG : FUNC_HALT)});
    rd_chk(OFF_DI_FUNC_BASE + 12'h5, {24'h0, FUNC_TRIG});
    foreach (sv[j])
    begin
      u_plc.drive({3'h0, sv[j]});
      repeat (4) @(posedge clk);
      u_plc.drive({3'h1, sv[j]});
      // select moves right after the trigger: a late sample would pick the new value
      u_plc.drive({3'h1, ~sv[j]});
      wait_ev(1'b0);
      chk(segment_start, 1'b1);
      chk(segment_number, sv[j]);
      u_plc.drive({3'h3, ~sv[j]});
      wait_ev(1'b1);
      chk(segment_halt, 1'b1);
      chk(segment_running, 1'b0);
      rd_chk(OFF_DI_LEVEL, {24'h0, 3'h3, ~sv[j]});
      u_plc.drive(8'h00);
    end
    $display("test terminals done");
    // dropping the enable mid-segment must end it
    wr_reg(OFF_SEG_CMD, 32'h2);
    chk(segment_start, 1'b1);
    @(posedge clk);
    servo_enabled <= 1'b0;
    rd_chk(OFF_SEG_CMD, {16'h0, STAT_DONE});
    chk(segment_running, 1'b0);
    wr_reg(OFF_SEG_CMD, 32'h4);
    chk(segment_start, 1'b0);
    $display("test disabled done");
    results;
  end
endmodule : position_segment_selector_tb_top
